// File: include/ipf_pkg.sv
package ipf_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_BASIC = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_PEND_LO = 12'h204;
    localparam logic [ADDR_W-1:0] OFF_PEND_HI = 12'h208;
    localparam logic [ADDR_W-1:0] OFF_FAST = 12'h20c;
    localparam logic [ADDR_W-1:0] OFF_EN_LO = 12'h210;
    localparam logic [ADDR_W-1:0] OFF_EN_HI = 12'h214;
    localparam logic [ADDR_W-1:0] OFF_EN_BAS = 12'h218;
    localparam logic [ADDR_W-1:0] OFF_DIS_LO = 12'h21c;
    localparam logic [ADDR_W-1:0] OFF_DIS_HI = 12'h220;
    localparam logic [ADDR_W-1:0] OFF_DIS_BAS = 12'h224;
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 12'h228;
    localparam logic [ADDR_W-1:0] OFF_ERRHALT = 12'h22c;
    // Basic pending layout
    localparam int BP_SUM_LO = 8;
    localparam int BP_SUM_HI = 9;
    localparam int BP_MIRROR_LSB = 10;
    localparam int BP_MIRROR_N = 11;
    localparam logic [31:0] MIRROR_LO = 32'h000c0680;
    localparam logic [31:0] MIRROR_HI = 32'h43e00000;
    // Control 1 and error/halt status layout
    localparam int CTRL_HALT_ALIAS = 10;
    localparam int ERR1_ADDR_BIT = 0;
    localparam int ERR1_BURST_BIT = 1;
    localparam int ERR0_BIT = 2;
    localparam int HALT0_BIT = 3;
    localparam int HALT1_BIT = 4;
    // Fast route control layout
    localparam int FAST_EN_BIT = 7;
    localparam int FAST_SEL_W = 7;
    localparam logic [6:0] FAST_SEL_LIMIT = 7'h48;
    localparam int COP_SRC_N = 64;
    // Reset values
    localparam logic [7:0] FAST_RST = 8'h00;
    localparam logic [31:0] EN_RST = 32'h0000_0000;
    localparam logic [7:0] EN_BAS_RST = 8'h00;
    localparam logic [2:0] ERR_RST = 3'h0;
    localparam logic CTRL_ALIAS_RST = 1'b0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ipf_pkg

// File: verilog/ipf_irq_top.sv
// What this block does
// R1: Basic bits 0..3 show timer, mailbox, doorbell 0, doorbell 1 pending.
// R2: Basic bits 4,5 show halt 0/1; bits 6,7 access error type 1/0.
// R3: Basic bits 10..20 mirror sources 7,9,10,18,19,53..57,62; 21..31 zero.
// R4: Basic bit 8 set by any pending-low bit outside the mirrored ones.
// R5: Basic bit 9 set by any pending-high bit outside bits 21..25, 30.
// R6: Pending-low is read-only, sources 0..31 including mirrored ones.
// R7: Pending-high is read-only, sources 32..63, source 32 at bit 0.
// R8: Access error type 0 on address bit 31/30 or host peripheral access.
// R9: Access error type 1 on address bits 29..26 or coprocessor burst.
// R10: Raw type 0 error at status bit 2, type 1 at bits 0,1.
// R11: Raw halt 1 at status bit 4, halt 0 at bit 3.
// R12: Control bit 10 lets halt 1 also raise halt 0 pending and fast source.
// R13: Fast route bit 7 enables; when clear the select field is ignored.
// R14: At most one source at a time drives the fast interrupt.
// R15: Select 0..63 picks the matching coprocessor source.
// R16: Select 64..71 picks local sources in order; 72..127 unused.
// R17: Sources are levels, held until disabled or cleared at source.
// R18: A pending bit reads set only when its enable is set.
// R19: Normal irq on any enabled pending; fast on the selected raw source, enables not applied.
//
// Register access over AXI4-Lite is this design's own decision.
module ipf_irq_top
    import ipf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [63:0] cop_irq_i,
    input wire logic timer_irq_i,
    input wire logic mailbox_irq_i,
    input wire logic doorbell0_irq_i,
    input wire logic doorbell1_irq_i,
    input wire logic cop0_halted_i,
    input wire logic cop1_halted_i,
    input wire logic host_acc_valid_i,
    input wire logic [31:0] host_acc_addr_i,
    input wire logic host_periph_acc_i,
    input wire logic cop_acc_valid_i,
    input wire logic [31:0] cop_acc_addr_i,
    input wire logic cop_burst_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic irq_o,
    output logic fast_interrupt_o
);

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a >= OFF_BASIC) && (a <= OFF_ERRHALT) && (a[1:0] == 2'h0);
    endfunction : addr_mapped

    logic [31:0] en_lo_reg;
    logic [31:0] en_hi_reg;
    logic [7:0] en_bas_reg;
    logic [7:0] fast_reg;
    logic alias_reg;
    logic [2:0] err_reg;
    logic awready_reg;
    logic wready_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic irq_reg;
    logic fast_out_reg;

    logic [7:0] bas_raw;
    logic [31:0] pend_lo;
    logic [31:0] pend_hi;
    logic [31:0] pend_basic;
    logic [71:0] src_all;
    logic fast_next;
    logic wr_do;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [2:0] err_set;
    logic [2:0] err_clr;
    logic [31:0] rd_val;

    // Local sources; halt 1 may stand in for halt 0 so one fast handler covers both
    always_comb begin
        bas_raw = {err_reg[ERR0_BIT], |err_reg[ERR1_BURST_BIT:ERR1_ADDR_BIT], cop1_halted_i,
                   cop0_halted_i | (alias_reg & cop1_halted_i),
                   doorbell1_irq_i, doorbell0_irq_i, mailbox_irq_i, timer_irq_i}; // R1 R2 R12
    end

    // Pending views are the live levels gated by enables
    assign pend_lo = cop_irq_i[31:0] & en_lo_reg; // R6 R17 R18
    assign pend_hi = cop_irq_i[63:32] & en_hi_reg; // R7 R17 R18

    always_comb begin
        pend_basic = 32'h0000_0000;
        pend_basic[7:0] = bas_raw & en_bas_reg; // R1 R2 R18
        pend_basic[BP_SUM_LO] = |(pend_lo & ~MIRROR_LO); // R4
        pend_basic[BP_SUM_HI] = |(pend_hi & ~MIRROR_HI); // R5
        pend_basic[BP_MIRROR_LSB +: BP_MIRROR_N] = {pend_hi[30], pend_hi[25:21], pend_lo[19],
                                                    pend_lo[18], pend_lo[10], pend_lo[9],
                                                    pend_lo[7]}; // R3
    end

    // Single mux: one source at most reaches the fast line
    assign src_all = {bas_raw, cop_irq_i}; // R15 R16
    always_comb begin
        fast_next = 1'b0;
        if (fast_reg[FAST_EN_BIT] && (fast_reg[FAST_SEL_W-1:0] < FAST_SEL_LIMIT)) begin // R13 R16
            fast_next = src_all[fast_reg[FAST_SEL_W-1:0]]; // R14 R15
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_reg <= 1'b0;
            fast_out_reg <= 1'b0;
        end else begin
            irq_reg <= |{pend_basic[7:0], pend_lo, pend_hi}; // R19
            fast_out_reg <= fast_next; // R19
        end
    end

    // Error detection; set beats a same-cycle clear
    always_comb begin
        err_set = 3'h0;
        err_set[ERR0_BIT] = (host_acc_valid_i & |host_acc_addr_i[31:30]) | host_periph_acc_i; // R8
        err_set[ERR1_ADDR_BIT] = cop_acc_valid_i & |cop_acc_addr_i[29:26]; // R9
        err_set[ERR1_BURST_BIT] = cop_burst_i; // R9
        err_clr = 3'h0;
        if (wr_do && (waddr_reg == OFF_ERRHALT)) begin
            err_clr = wbits[ERR0_BIT:ERR1_ADDR_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            err_reg <= ERR_RST;
        end else begin
            err_reg <= (err_reg & ~err_clr) | err_set; // R8 R9
        end
    end

    // Write channel: address and data taken in either order
    assign wr_do = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wmask = lane_mask(wstrb_reg);
    assign wbits = wdata_reg & wmask;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            awready_reg <= 1'b1;
            aw_got_reg <= 1'b0;
            waddr_reg <= '0;
        end else if (s_axi_awvalid_i && awready_reg) begin
            awready_reg <= 1'b0;
            aw_got_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr_i;
        end else if (wr_do) begin
            aw_got_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready_i) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wready_reg <= 1'b1;
            w_got_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid_i && wready_reg) begin
            wready_reg <= 1'b0;
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
        end else if (wr_do) begin
            w_got_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready_i) begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Pending registers have no write effect
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            en_lo_reg <= EN_RST;
            en_hi_reg <= EN_RST;
            en_bas_reg <= EN_BAS_RST;
        end else if (wr_do) begin
            unique case (waddr_reg)
                OFF_EN_LO: en_lo_reg <= en_lo_reg | wbits;
                OFF_EN_HI: en_hi_reg <= en_hi_reg | wbits;
                OFF_EN_BAS: en_bas_reg <= en_bas_reg | wbits[7:0];
                OFF_DIS_LO: en_lo_reg <= en_lo_reg & ~wbits;
                OFF_DIS_HI: en_hi_reg <= en_hi_reg & ~wbits;
                OFF_DIS_BAS: en_bas_reg <= en_bas_reg & ~wbits[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            fast_reg <= FAST_RST;
            alias_reg <= CTRL_ALIAS_RST;
        end else if (wr_do) begin
            if ((waddr_reg == OFF_FAST) && wstrb_reg[0]) begin
                fast_reg <= wdata_reg[7:0]; // R13
            end
            if ((waddr_reg == OFF_CTRL1) && wstrb_reg[1]) begin
                alias_reg <= wdata_reg[CTRL_HALT_ALIAS]; // R12
            end
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr_i)
            OFF_BASIC: rd_val = pend_basic; // R3
            OFF_PEND_LO: rd_val = pend_lo; // R6
            OFF_PEND_HI: rd_val = pend_hi; // R7
            OFF_FAST: rd_val[7:0] = fast_reg;
            OFF_EN_LO, OFF_DIS_LO: rd_val = en_lo_reg;
            OFF_EN_HI, OFF_DIS_HI: rd_val = en_hi_reg;
            OFF_EN_BAS, OFF_DIS_BAS: rd_val[7:0] = en_bas_reg;
            OFF_CTRL1: rd_val[CTRL_HALT_ALIAS] = alias_reg;
            OFF_ERRHALT: rd_val[HALT1_BIT:ERR1_ADDR_BIT] = {cop1_halted_i, cop0_halted_i,
                                                           err_reg}; // R10 R11
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid_i && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign irq_o = irq_reg;
    assign fast_interrupt_o = fast_out_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic ar_take;
    assign ar_take = s_axi_arvalid_i && arready_reg;
    logic fast_cop_sel;
    assign fast_cop_sel = cop_irq_i[fast_reg[5:0]];

    a_basic_local: assert property (en_bas_reg[3:0] == 4'hf |->
        pend_basic[3:0] == {doorbell1_irq_i, doorbell0_irq_i, mailbox_irq_i, timer_irq_i}) // R1
        else $error("local pending bits out of order");
    a_basic_halt: assert property (en_bas_reg[5] && !en_bas_reg[4] |->
        pend_basic[5] == cop1_halted_i && !pend_basic[4]) // R2
        else $error("halt pending bit wrong");
    a_mirror_bits: assert property (pend_basic[20:10] == {pend_hi[30], pend_hi[25:21],
        pend_lo[19:18], pend_lo[10:9], pend_lo[7]} && pend_basic[31:21] == 11'h0) // R3
        else $error("mirrored bits wrong");
    a_summary_low: assert property ((pend_lo & ~MIRROR_LO) == 32'h0 |->
        !pend_basic[BP_SUM_LO]) // R4
        else $error("summary low set by mirrored source");
    a_summary_high: assert property (pend_hi[0] |-> pend_basic[BP_SUM_HI]) // R5
        else $error("summary high missed source 32");
    a_pend_view: assert property (ar_take && s_axi_araddr_i == OFF_PEND_HI |=>
        rdata_reg == ($past(cop_irq_i[63:32]) & $past(en_hi_reg))) // R7
        else $error("pending high read wrong");
    a_gate_enable: assert property (en_lo_reg == 32'h0 |-> pend_lo == 32'h0) // R6 R18
        else $error("pending shown without enable");
    a_err0_set: assert property (host_acc_valid_i && host_acc_addr_i[30] |=>
        err_reg[ERR0_BIT]) // R8
        else $error("type 0 error not latched");
    a_err1_set: assert property (cop_burst_i ##1 !wr_do |=> err_reg[ERR1_BURST_BIT]) // R9
        else $error("type 1 burst error lost");
    a_err_read: assert property (ar_take && s_axi_araddr_i == OFF_ERRHALT |=>
        rdata_reg[4:0] == {$past(cop1_halted_i), $past(cop0_halted_i), $past(err_reg)}) // R10 R11
        else $error("error/halt status read wrong");
    a_halt_alias: assert property (alias_reg && cop1_halted_i && en_bas_reg[4] |->
        pend_basic[4]) // R12
        else $error("halt alias not applied");
    a_fast_off: assert property (!fast_reg[FAST_EN_BIT] |=> !fast_interrupt_o) // R13
        else $error("fast line active while disabled");
    a_fast_cop: assert property (fast_reg[FAST_EN_BIT] && fast_reg[6] == 1'b0 |=>
        fast_interrupt_o == $past(fast_cop_sel)) // R14 R15
        else $error("fast route to coprocessor source wrong");
    a_fast_local: assert property (fast_reg == 8'hc7 |=>
        fast_interrupt_o == $past(err_reg[ERR0_BIT])) // R16
        else $error("fast route select 71 wrong");
    a_irq_level: assert property (pend_lo[0] ##1 pend_lo[0] |-> irq_o) // R17 R19
        else $error("irq dropped while source pending");

    c_fast_fire: cover property (fast_reg[FAST_EN_BIT] ##1 fast_interrupt_o);
    c_irq_fire: cover property (!irq_o ##1 irq_o);
    c_write_done: cover property (bvalid_reg && s_axi_bready_i);
    c_read_basic: cover property (ar_take && s_axi_araddr_i == OFF_BASIC);

endmodule : ipf_irq_top

// File: tb/ipf_src_model.sv
module ipf_src_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [63:0] cop_req_i,
    input wire logic [5:0] loc_req_i,
    output logic [63:0] cop_irq_o,
    output logic [5:0] loc_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sources hold their level until told to drop it, never pulse
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cop_irq_o <= 64'h0;
            loc_irq_o <= 6'h00;
        end else begin
            cop_irq_o <= cop_req_i;
            loc_irq_o <= loc_req_i;
        end
    end
endmodule : ipf_src_model

// File: tb/irq_pending_and_fast_route_bench.sv
module irq_pending_and_fast_route_bench
    import ipf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MIR[11] = '{7, 9, 10, 18, 19, 53, 54, 55, 56, 57, 62};
    logic core_clk, sys_rst = 1'b1;
    logic [63:0] cop_req = 64'h0;
    logic [5:0] loc_req = 6'h00;
    logic [63:0] cop_irq;
    logic [5:0] loc_irq;
    logic hv = 1'b0, hp = 1'b0, cv = 1'b0, cb = 1'b0;
    logic [31:0] ha = 32'h0, ca = 32'h0, wdata = 32'h0, rdata, rd_val;
    logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, fast;
    logic [1:0] bresp, rresp, last_resp;
    int errors = 0, n_compared = 0, cyc = 0;

    ipf_src_model u_ipf_src_model (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
        .cop_req_i(cop_req), .loc_req_i(loc_req), .cop_irq_o(cop_irq), .loc_irq_o(loc_irq));
    ipf_irq_top u_ipf_irq_top (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .cop_irq_i(cop_irq),
        .timer_irq_i(loc_irq[0]), .mailbox_irq_i(loc_irq[1]), .doorbell0_irq_i(loc_irq[2]),
        .doorbell1_irq_i(loc_irq[3]), .cop0_halted_i(loc_irq[4]), .cop1_halted_i(loc_irq[5]),
        .host_acc_valid_i(hv), .host_acc_addr_i(ha), .host_periph_acc_i(hp),
        .cop_acc_valid_i(cv), .cop_acc_addr_i(ca), .cop_burst_i(cb),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq),
        .fast_interrupt_o(fast));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // Hang guard, far above the fewer than two thousand cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!bvalid);
        last_resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        rd_val = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(what, rd_val, e);
    endtask : rd_chk

    // Sources pass through the model and the design's flops before they show
    task automatic set_src(input logic [63:0] c, input logic [5:0] l);
        @(posedge core_clk);
        cop_req <= c;
        loc_req <= l;
        repeat (4) @(posedge core_clk);
    endtask : set_src

    // Expected summary with every enable set; err is {type0, type1}
    function automatic logic [31:0] exp_basic(logic [63:0] c, logic [5:0] l, logic [1:0] err);
        logic [31:0] b = {22'h0, 2'h0, err, l};
        logic [63:0] rest = c;
        for (int i = 0; i < 11; i++) begin
            b[10+i] = c[MIR[i]];
            rest[MIR[i]] = 1'b0;
        end
        b[8] = |rest[31:0];
        b[9] = |rest[63:32];
        return b;
    endfunction : exp_basic

    task automatic t_reset_and_map();
        rd_chk("basic", OFF_BASIC, 32'h0);
        rd_chk("pend_lo", OFF_PEND_LO, 32'h0);
        rd_chk("pend_hi", OFF_PEND_HI, 32'h0);
        rd_chk("fast_ctl", OFF_FAST, 32'h0);
        axi_rd(12'h300);
        chk("unmapped resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
    endtask : t_reset_and_map

    task automatic t_pending();
        logic [63:0] m = 64'h0;
        for (int i = 0; i < 11; i++) m[MIR[i]] = 1'b1;
        axi_wr(OFF_EN_LO, 32'hffffffff);
        axi_wr(OFF_EN_HI, 32'hffffffff);
        axi_wr(OFF_EN_BAS, 32'h000000ff);
        set_src(m, 6'h00);
        rd_chk("basic mirror", OFF_BASIC, exp_basic(m, 6'h00, 2'h0));
        rd_chk("pend_lo", OFF_PEND_LO, m[31:0]);
        rd_chk("pend_hi", OFF_PEND_HI, m[63:32]);
        set_src(m | 64'h1, 6'h00);
        rd_chk("basic sum lo", OFF_BASIC, exp_basic(m | 64'h1, 6'h00, 2'h0));
        set_src(m | 64'h1_0000_0000, 6'h00);
        rd_chk("basic sum hi", OFF_BASIC, exp_basic(m | 64'h1_0000_0000, 6'h00, 2'h0));
        axi_wr(OFF_PEND_LO, 32'hffffffff);
        chk("pend_lo wr resp", {30'h0, last_resp}, {30'h0, RESP_OKAY});
        rd_chk("pend_lo ro", OFF_PEND_LO, m[31:0]);
        axi_wr(OFF_DIS_HI, 32'h00000001);
        rd_chk("pend_hi masked", OFF_PEND_HI, m[63:32]);
        axi_wr(OFF_EN_HI, 32'h00000001);
    endtask : t_pending

    task automatic t_local();
        set_src(64'h0, 6'h3f);
        rd_chk("basic local", OFF_BASIC, 32'h0000003f);
        chk("irq on", {31'h0, irq}, 32'h1);
        axi_wr(OFF_DIS_BAS, 32'h000000ff);
        rd_chk("basic masked", OFF_BASIC, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        axi_wr(OFF_EN_BAS, 32'h000000ff);
        set_src(64'h0, 6'h20);
        rd_chk("status halt1", OFF_ERRHALT, 32'h00000010);
        rd_chk("basic halt1", OFF_BASIC, 32'h00000020);
        axi_wr(OFF_DIS_BAS, 32'h00000010);
        rd_chk("basic halt0 off", OFF_BASIC, 32'h00000020);
        axi_wr(OFF_EN_BAS, 32'h00000010);
        axi_wr(OFF_CTRL1, 32'h00000400);
        rd_chk("basic alias", OFF_BASIC, 32'h00000030);
        axi_wr(OFF_FAST, 32'h000000c4);
        repeat (3) @(posedge core_clk);
        chk("fast alias", {31'h0, fast}, 32'h1);
        axi_wr(OFF_CTRL1, 32'h0);
        set_src(64'h0, 6'h10);
        rd_chk("status halt0", OFF_ERRHALT, 32'h00000008);
        set_src(64'h0, 6'h00);
    endtask : t_local

    task automatic t_errors();
        logic [31:0] st;
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            hv <= (k < 2);
            ha <= (k == 0) ? 32'h80000000 : 32'h40000000;
            hp <= (k == 2);
            cv <= (k == 3 || k == 4);
            ca <= (k == 3) ? 32'h04000000 : 32'h20000000;
            cb <= (k == 5);
            @(posedge core_clk);
            {hv, hp, cv, cb} <= 4'h0;
            repeat (3) @(posedge core_clk);
            st = (k < 3) ? 32'h4 : (k < 5) ? 32'h1 : 32'h2;
            rd_chk("err status", OFF_ERRHALT, st);
            rd_chk("basic err", OFF_BASIC, exp_basic(64'h0, 6'h0, {st[2], |st[1:0]}));
            axi_wr(OFF_FAST, (k < 3) ? 32'h000000c7 : 32'h000000c6);
            repeat (3) @(posedge core_clk);
            chk("fast err", {31'h0, fast}, 32'h1);
            axi_wr(OFF_ERRHALT, 32'h00000007);
            rd_chk("err cleared", OFF_ERRHALT, 32'h0);
        end
    endtask : t_errors

    task automatic t_fast();
        logic [69:0] all;
        for (int s = 0; s < 70; s++) begin
            all = '1;
            all[s] = 1'b0;
            axi_wr(OFF_FAST, 32'h80 | s);
            set_src(all[63:0], all[69:64]);
            chk("fast others", {31'h0, fast}, 32'h0);
            set_src(64'hffffffffffffffff, 6'h3f);
            chk("fast chosen", {31'h0, fast}, 32'h1);
        end
        axi_wr(OFF_FAST, 32'h00000005);
        repeat (3) @(posedge core_clk);
        chk("fast disabled", {31'h0, fast}, 32'h0);
        axi_wr(OFF_FAST, 32'h000000c7);
        repeat (3) @(posedge core_clk);
        chk("fast sel 71 idle", {31'h0, fast}, 32'h0);
        set_src(64'h0, 6'h00);
    endtask : t_fast

    initial begin
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset_and_map();
        t_pending();
        t_local();
        t_errors();
        t_fast();
        tally_and_finish();
    end
endmodule : irq_pending_and_fast_route_bench
